/* File: design/gwt_pkg.sv */
// Constants, field layouts and types for the gated width overflow timer
package gwt_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MODE_CONFIG = 8'h00;
    localparam logic [7:0] OFS_EDGE_CONFIG = 8'h04;
    localparam logic [7:0] OFS_DATA_REG = 8'h08;
    localparam logic [7:0] OFS_COUNTER = 8'h0c;
    localparam logic [7:0] OFS_TRIGGER = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ------------------------------------------------------------------
    // Bit positions in the trigger and status registers
    // ------------------------------------------------------------------
    localparam int TRIG_START_BIT = 0;
    localparam int TRIG_STOP_BIT = 1;
    localparam int STAT_ENABLE_BIT = 0;
    localparam int STAT_OVERFLOW_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] EDGE_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'hffff;
    localparam logic [15:0] MODE_WMASK = 16'hdfdf;
    localparam logic [15:0] EDGE_WMASK = 16'h0003;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // ------------------------------------------------------------------
    // Counter values
    // ------------------------------------------------------------------
    localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_STEP = 16'h0001;

    // ------------------------------------------------------------------
    // Mode and edge select codes
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_GATE_COUNT = 4'hc;
    localparam logic [3:0] MODE_CAPTURE_GATE = 4'hd;
    localparam logic [1:0] EDGE_FALLING = 2'h0;
    localparam logic [1:0] EDGE_RISING = 2'h1;
    localparam logic [1:0] EDGE_LOW_WIDTH = 2'h2;
    localparam logic [1:0] EDGE_HIGH_WIDTH = 2'h3;

    // ------------------------------------------------------------------
    // Field layout of the channel mode configuration register
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] clock_select;
        logic rsv_13;
        logic count_clock_select;
        logic master_select;
        logic [2:0] trigger_source;
        logic [1:0] overflow_status_control;
        logic rsv_5;
        logic [3:0] mode_field;
        logic mode_low_bit;
    } gwt_mode_config_type;

    // Register bus request bundle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } gwt_bus_req_type;

    // Channel operating states
    typedef enum logic [1:0] {
        ST_STOPPED,
        ST_ARMED,
        ST_COUNTING,
        ST_PAUSED
    } gwt_state_type;

endpackage : gwt_pkg

/* File: design/gwt_timer.sv */
// One gated width overflow timer channel with its register port
`timescale 1ns/1ps
`default_nettype none

module gwt_timer
    import gwt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire gwt_bus_req_type bus_req,
    output logic [DATA_W-1:0] rdata,
    input wire logic prescaled_clock_a,
    input wire logic prescaled_clock_b,
    input wire logic prescaled_clock_c,
    input wire logic prescaled_clock_d,
    input wire logic timer_input,
    output logic channel_interrupt,
    output logic channel_enable_status
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------

    // Start edge for the programmed edge selection
    function automatic logic is_start_edge(input logic [1:0] sel,
                                           input logic rise,
                                           input logic fall);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            EDGE_FALLING: hit = fall;
            EDGE_RISING: hit = rise;
            EDGE_LOW_WIDTH: hit = fall;
            EDGE_HIGH_WIDTH: hit = rise;
        endcase
        return hit;
    endfunction : is_start_edge

    // Stop edge: the reverse edge, only in the two width codes
    // Codes 00 and 01 never stop the count once it has begun
    function automatic logic is_stop_edge(input logic [1:0] sel,
                                          input logic rise,
                                          input logic fall);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            EDGE_FALLING: hit = 1'b0;
            EDGE_RISING: hit = 1'b0;
            EDGE_LOW_WIDTH: hit = rise;
            EDGE_HIGH_WIDTH: hit = fall;
        endcase
        return hit;
    endfunction : is_stop_edge

    // Address match for one register offset
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [7:0] ofs);
        return addr == ofs;
    endfunction : addr_hit

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    gwt_mode_config_type channel_mode_config;
    logic [15:0] channel_input_edge_config;
    logic [15:0] channel_data_reg;
    logic [15:0] channel_counter;
    logic overflow_flag;
    gwt_state_type state;
    logic input_sync1;
    logic input_sync2;
    logic input_prev;

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    // Write strobes per register; unmapped offsets match nothing
    wire logic wr_mode = bus_req.wr && addr_hit(bus_req.addr, OFS_MODE_CONFIG);
    wire logic wr_edge = bus_req.wr && addr_hit(bus_req.addr, OFS_EDGE_CONFIG);
    wire logic wr_data = bus_req.wr && addr_hit(bus_req.addr, OFS_DATA_REG);
    wire logic wr_trig = bus_req.wr && addr_hit(bus_req.addr, OFS_TRIGGER);
    wire logic wr_stat = bus_req.wr && addr_hit(bus_req.addr, OFS_STATUS);

    // One-shot triggers exist only for the write cycle, never stored, so
    // a read of the trigger offset always returns zero
    wire logic start_trig =
        wr_trig && bus_req.wdata[TRIG_START_BIT];
    wire logic stop_trig =
        wr_trig && bus_req.wdata[TRIG_STOP_BIT];
    wire logic ovf_clear = wr_stat && bus_req.wdata[STAT_OVERFLOW_BIT];

    // ------------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------------

    // Operation clock from the four prescaled tick inputs
    // The ticks are one-cycle enables, not clocks, so all logic stays on clk
    wire logic [3:0] prescaled_ticks = {prescaled_clock_d, prescaled_clock_c,
                                        prescaled_clock_b, prescaled_clock_a};
    wire logic count_tick =
        prescaled_ticks[channel_mode_config.clock_select];

    // ------------------------------------------------------------------
    // Timer input edges
    // ------------------------------------------------------------------

    // Edges come from the second and third stages only
    wire logic input_rise = input_sync2 && !input_prev;
    wire logic input_fall = !input_sync2 && input_prev;
    wire logic [1:0] edge_sel = channel_input_edge_config[1:0];
    wire logic start_edge = is_start_edge(edge_sel, input_rise,
                                          input_fall);
    wire logic stop_edge = is_stop_edge(edge_sel, input_rise,
                                        input_fall);

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Any mode code other than capture behaves as gate count
    wire logic capture_mode =
        channel_mode_config.mode_field == MODE_CAPTURE_GATE;
    wire logic counter_at_zero = channel_counter == CNT_ZERO;
    wire logic counter_at_ones = channel_counter == CNT_ALL_ONES;

    // A tick that meets a stop edge or a stop trigger is not counted,
    // so no wrap may be flagged for it either: the counter keeps its value
    wire logic tick_blocked = stop_trig || stop_edge;

    // Wrap events while the gate is open and a count tick arrives
    wire logic counting_tick = (state == ST_COUNTING) && count_tick
                               && !tick_blocked;
    wire logic gate_wrap = counting_tick && !capture_mode
                           && counter_at_zero;
    wire logic capture_ovf = counting_tick && capture_mode && counter_at_ones;
    wire logic capture_stop = (state == ST_COUNTING) && capture_mode
                              && stop_edge;

    // ------------------------------------------------------------------
    // Next state and counter
    // ------------------------------------------------------------------
    gwt_state_type next_state;
    logic [15:0] next_counter;

    // Channel sequencing: stop wins over start in the same write
    always_comb begin
        next_state = state;
        next_counter = channel_counter;
        if (stop_trig) begin
            next_state = ST_STOPPED;
        end else begin
            unique case (state)
                ST_STOPPED: begin
                    // Edges cannot act here, only the start trigger
                    if (start_trig) begin
                        next_state = ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    // Fresh load on the first start edge after arming
                    if (start_edge) begin
                        next_state = ST_COUNTING;
                        if (capture_mode) begin
                            next_counter = CNT_ZERO;
                        end else begin
                            next_counter = channel_data_reg;
                        end
                    end
                end
                ST_COUNTING: begin
                    // Stop edge first: a tick in the same cycle is dropped
                    if (stop_edge) begin
                        next_state = ST_PAUSED;
                    end else if (count_tick) begin
                        if (capture_mode) begin
                            next_counter = channel_counter + CNT_STEP;
                        end else if (counter_at_zero) begin
                            next_counter = channel_data_reg;
                        end else begin
                            next_counter =
                                channel_counter - CNT_STEP;
                        end
                    end
                end
                ST_PAUSED: begin
                    // Resume from the kept value, no reload
                    if (start_edge) begin
                        next_state = ST_COUNTING;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Channel state registers
    // ------------------------------------------------------------------

    // State, counter and enable status; start while running is ignored
    // The enable status follows the next state so it tracks stop and start
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_STOPPED;
            channel_counter <= CNT_ZERO;
            channel_enable_status <= 1'b0;
        end else begin
            state <= next_state;
            channel_counter <= next_counter;
            channel_enable_status <= next_state != ST_STOPPED;
        end
    end

    // Timer input synchroniser and edge history; the first stage may go
    // metastable, so only the second and history stages are read, and the history stage
    // resets low so an input held low gives no false edge after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            input_sync1 <= 1'b0;
            input_sync2 <= 1'b0;
            input_prev <= 1'b0;
        end else begin
            input_sync1 <= timer_input;
            input_sync2 <= input_sync1;
            input_prev <= input_sync2;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and status flags
    // ------------------------------------------------------------------

    // Interrupt pulse: one cycle per gate count wrap or per capture
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_interrupt <= 1'b0;
        end else begin
            channel_interrupt <= gate_wrap || capture_stop;
        end
    end

    // Overflow flag of capture mode; a new overflow beats the clear
    // The flag only ever sets in capture mode; gate mode never touches it
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (capture_ovf) begin
            overflow_flag <= 1'b1;
        end else if (ovf_clear) begin
            overflow_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Mode and edge configuration with reserved bits held at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_mode_config <= MODE_RESET;
            channel_input_edge_config <= EDGE_RESET;
        end else begin
            if (wr_mode) begin
                channel_mode_config <= bus_req.wdata & MODE_WMASK;
            end
            if (wr_edge) begin
                channel_input_edge_config <= bus_req.wdata & EDGE_WMASK;
            end
        end
    end

    // Data register; capture mode stores the measured width on a stop edge
    // A capture beats a software write that falls in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_data_reg <= DATA_RESET;
        end else if (capture_stop) begin
            channel_data_reg <= channel_counter;
        end else if (wr_data) begin
            channel_data_reg <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Status word and read selection; reading never touches the count
    wire logic [15:0] status_word = {14'h0000, overflow_flag,
                                     channel_enable_status};
    logic [15:0] read_mux;
    always_comb begin
        read_mux = ZERO_WORD;
        if (addr_hit(bus_req.addr, OFS_MODE_CONFIG)) begin
            read_mux = channel_mode_config;
        end else if (addr_hit(bus_req.addr, OFS_EDGE_CONFIG)) begin
            read_mux = channel_input_edge_config;
        end else if (addr_hit(bus_req.addr, OFS_DATA_REG)) begin
            read_mux = channel_data_reg;
        end else if (addr_hit(bus_req.addr, OFS_COUNTER)) begin
            read_mux = channel_counter;
        end else if (addr_hit(bus_req.addr, OFS_STATUS)) begin
            read_mux = status_word;
        end
    end

    // Read data stand only in the cycle after the strobe
    // and fall back to zero so a stale word is never taken twice
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= ZERO_WORD;
        end else if (bus_req.rd) begin
            rdata <= read_mux;
        end else begin
            rdata <= ZERO_WORD;
        end
    end

endmodule : gwt_timer

`default_nettype wire

/* File: bench/gwt_timer_assertions.sv */
// Port-level assertions for the gated width overflow timer
`timescale 1ns/1ps
`default_nettype none

module gwt_timer_chk
    import gwt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire gwt_bus_req_type bus_req,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic prescaled_clock_a,
    input wire logic prescaled_clock_b,
    input wire logic prescaled_clock_c,
    input wire logic prescaled_clock_d,
    input wire logic timer_input,
    input wire logic channel_interrupt,
    input wire logic channel_enable_status
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Trigger writes and tick decode; stop wins over start
    wire logic trig_wr = bus_req.wr && bus_req.addr == OFS_TRIGGER;
    wire logic halt_wr = trig_wr && bus_req.wdata[TRIG_STOP_BIT];
    wire logic go_wr = trig_wr && bus_req.wdata[TRIG_START_BIT] && !halt_wr;
    wire logic any_tick = prescaled_clock_a || prescaled_clock_b
        || prescaled_clock_c || prescaled_clock_d;

    stop_clears_a: assert property (
        halt_wr |=> !channel_enable_status)
        else $error("enable still set after stop");
    enable_fall_a: assert property (
        $fell(channel_enable_status) |-> $past(halt_wr) || $past(rst))
        else $error("enable dropped without stop");
    start_sets_a: assert property (
        go_wr |=> channel_enable_status)
        else $error("enable not set by start");
    enable_rise_a: assert property (
        $rose(channel_enable_status) |-> $past(go_wr))
        else $error("enable rose without start");
    stopped_stays_a: assert property (
        !channel_enable_status && !go_wr |=> !channel_enable_status)
        else $error("channel left stop without start");
    irq_enabled_a: assert property (
        channel_interrupt |-> $past(channel_enable_status))
        else $error("interrupt while stopped");
    irq_pulse_a: assert property (
        channel_interrupt && !any_tick |=> !channel_interrupt)
        else $error("interrupt longer than one cycle");
    trig_reads_a: assert property (
        bus_req.rd && bus_req.addr == OFS_TRIGGER |=> rdata == ZERO_WORD)
        else $error("trigger bits read nonzero");
    status_read_a: assert property (
        bus_req.rd && bus_req.addr == OFS_STATUS
        |=> rdata[STAT_ENABLE_BIT] == $past(channel_enable_status))
        else $error("status bit differs from enable");
    rdata_idle_a: assert property (
        !$past(bus_req.rd) |-> rdata == ZERO_WORD)
        else $error("read data outside read slot");
endmodule : gwt_timer_chk

bind gwt_timer gwt_timer_chk chk_u (.clk(clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .prescaled_clock_a(prescaled_clock_a),
    .prescaled_clock_b(prescaled_clock_b),
    .prescaled_clock_c(prescaled_clock_c),
    .prescaled_clock_d(prescaled_clock_d), .timer_input(timer_input),
    .channel_interrupt(channel_interrupt),
    .channel_enable_status(channel_enable_status));

`default_nettype wire

/* File: bench/gwt_pulse_src.sv */
// Model of the external pulse source on the timer input
`timescale 1ns/1ps
`default_nettype none

module gwt_pulse_src (
    input wire logic clk,
    input wire logic rst,
    input wire logic level_req,
    input wire logic slow,
    output logic timer_input
);
    logic [3:0] dly;

    // Follow the requested level after one cycle, or five when slow
    always_ff @(posedge clk) begin
        if (rst) begin
            dly <= 4'h0;
            timer_input <= 1'b0;
        end else begin
            dly <= {dly[2:0], level_req};
            timer_input <= slow ? dly[3] : level_req;
        end
    end
endmodule : gwt_pulse_src

`default_nettype wire

/* File: bench/test_gwt_timer.sv */
// Self-checking bench for the gated width overflow timer
`timescale 1ns/1ps
`default_nettype none

module test_gwt_timer
    import gwt_pkg::*;
;
    logic clk;
    logic rst;
    gwt_bus_req_type bus_req;
    logic [DATA_W-1:0] rdata;
    logic [3:0] tick;
    logic want;
    logic slow;
    logic timer_input;
    logic irq;
    logic en;
    logic rd_d;
    logic [15:0] exp_q[$];
    logic [15:0] cnt;
    logic [31:0] seed = 32'h00000053;
    int num_errors = 0;
    int checks_done = 0;
    int irq_n = 0;
    int cyc = 0;

    gwt_timer dut_u (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .prescaled_clock_a(tick[0]), .prescaled_clock_b(tick[1]),
        .prescaled_clock_c(tick[2]), .prescaled_clock_d(tick[3]),
        .timer_input(timer_input), .channel_interrupt(irq),
        .channel_enable_status(en));
    gwt_pulse_src src_u (.clk(clk), .rst(rst), .level_req(want), .slow(slow),
        .timer_input(timer_input));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // Read strobe; the expected word is noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge clk);
        bus_req.rd <= 1'b0;
    endtask : rd

    task automatic tk(input int s, input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 4'(1 << s);
            @(posedge clk);
            tick <= 4'h0;
        end
    endtask : tk

    // Move the input and let the synchroniser settle
    task automatic lvl(input logic v);
        @(posedge clk);
        want <= v;
        repeat (10) @(posedge clk);
    endtask : lvl

    task end_sim();
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Watcher: read data against oldest note, interrupt count, hang limit
    always @(posedge clk) begin
        rd_d <= bus_req.rd;
        if (irq === 1'b1)
            irq_n++;
        if (rd_d === 1'b1)
            chk("rdata", exp_q.pop_front(), rdata);
        cyc++;
        if (cyc > 6000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1;
        bus_req = '0;
        tick = 4'h0;
        want = 1'b0;
        slow = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset values, masks, read-only and unmapped places
        rd(OFS_MODE_CONFIG, MODE_RESET);
        rd(OFS_EDGE_CONFIG, EDGE_RESET);
        rd(OFS_DATA_REG, DATA_RESET);
        rd(OFS_STATUS, ZERO_WORD);
        repeat (3) begin
            cnt = 16'(xs());
            wr(OFS_MODE_CONFIG, cnt);
            wr(OFS_EDGE_CONFIG, cnt);
            wr(OFS_DATA_REG, cnt);
            wr(OFS_COUNTER, cnt);
            wr(8'h40, cnt);
            rd(OFS_MODE_CONFIG, cnt & MODE_WMASK);
            rd(OFS_EDGE_CONFIG, cnt & EDGE_WMASK);
            rd(OFS_DATA_REG, cnt);
            rd(OFS_COUNTER, CNT_ZERO);
            rd(8'h40, ZERO_WORD);
            rd(OFS_TRIGGER, ZERO_WORD);
        end
        // Gate count setup, edges while stopped, then arm
        wr(OFS_MODE_CONFIG, 16'h0218);
        wr(OFS_EDGE_CONFIG, {14'h0, EDGE_HIGH_WIDTH});
        wr(OFS_DATA_REG, CNT_ALL_ONES);
        lvl(1'b1);
        lvl(1'b0);
        tk(0, 2);
        rd(OFS_COUNTER, CNT_ZERO);
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_STATUS, 16'h0001);
        chk("enable", 16'h0001, 16'(en));
        rd(OFS_TRIGGER, ZERO_WORD);
        tk(0, 2);
        rd(OFS_COUNTER, CNT_ZERO);
        lvl(1'b1);
        rd(OFS_COUNTER, CNT_ALL_ONES);
        tk(0, 3);
        tk(1, 2);
        rd(OFS_COUNTER, 16'hfffc);
        lvl(1'b0);
        tk(0, 2);
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_COUNTER, 16'hfffc);
        lvl(1'b1);
        rd(OFS_COUNTER, 16'hfffc);
        cnt = 16'hfffc;
        for (int s = 0; s < 4; s++) begin
            wr(OFS_MODE_CONFIG, 16'h0218 | 16'(s << 14));
            tk((s + 1) % 4, 1);
            tk(s, 1);
            cnt = cnt - CNT_STEP;
            rd(OFS_COUNTER, cnt);
        end
        // Stop keeps the count and deafens the input
        wr(OFS_TRIGGER, 16'h0002);
        rd(OFS_STATUS, ZERO_WORD);
        chk("enable", 16'h0000, 16'(en));
        lvl(1'b0);
        lvl(1'b1);
        tk(3, 2);
        rd(OFS_COUNTER, cnt);
        chk("irq", 16'h0000, 16'(irq_n));
        // Wrap through zero with a short reload, slow source
        wr(OFS_DATA_REG, 16'h0003);
        wr(OFS_TRIGGER, 16'h0003);
        rd(OFS_STATUS, ZERO_WORD);
        slow <= 1'b1;
        lvl(1'b0);
        wr(OFS_TRIGGER, 16'h0001);
        lvl(1'b1);
        rd(OFS_COUNTER, 16'h0003);
        tk(3, 4);
        rd(OFS_COUNTER, 16'h0003);
        chk("irq", 16'h0001, 16'(irq_n));
        tk(3, 4);
        rd(OFS_COUNTER, 16'h0003);
        chk("irq", 16'h0002, 16'(irq_n));
        // Low width: falling edge starts, rising edge stops
        wr(OFS_TRIGGER, 16'h0002);
        wr(OFS_EDGE_CONFIG, {14'h0, EDGE_LOW_WIDTH});
        wr(OFS_TRIGGER, 16'h0001);
        lvl(1'b0);
        tk(3, 1);
        lvl(1'b1);
        tk(3, 2);
        rd(OFS_COUNTER, 16'h0002);
        // Capture mode restarts from zero after a stop
        wr(OFS_TRIGGER, 16'h0002);
        wr(OFS_MODE_CONFIG, 16'h021a);
        wr(OFS_EDGE_CONFIG, {14'h0, EDGE_HIGH_WIDTH});
        lvl(1'b0);
        wr(OFS_TRIGGER, 16'h0001);
        lvl(1'b1);
        tk(0, 2);
        rd(OFS_COUNTER, 16'h0002);
        wr(OFS_TRIGGER, 16'h0002);
        lvl(1'b0);
        wr(OFS_TRIGGER, 16'h0001);
        lvl(1'b1);
        rd(OFS_COUNTER, CNT_ZERO);
        chk("irq", 16'h0002, 16'(irq_n));
        repeat (4) @(posedge clk);
        end_sim();
    end
endmodule : test_gwt_timer

`default_nettype wire
